// ---- core/mai_intensity_ctrl.sv ----
// Master and auxiliary intensity register with PWM output generation
`timescale 1ns/1ns
`default_nettype none
module mai_intensity_ctrl #(
  parameter int NUM_PORTS = 8,
  parameter int SLOT_DIV  = mai_pkg::SLOT_CYCLES
) (
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 reset,
  // Register access from the serial interface
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  input  wire logic [7:0]           reg_addr,
  input  wire logic [7:0]           reg_wdata,
  output logic [7:0]                reg_rdata,
  output logic                      reg_rvalid,
  // General port controls from the port logic
  input  wire logic [NUM_PORTS-1:0] port_enable,
  input  wire logic [NUM_PORTS-1:0] port_phase_sel,
  input  wire logic                 blink_phase,
  // Outputs, high means sinking
  output logic [NUM_PORTS-1:0]      general_port_on,
  output logic                      aux_output_port_on,
  output logic                      master_pwm_on
);
  typedef struct packed {
    logic [7:0]           intens;
    logic                 phase;
    logic [7:0]           rdata;
    logic                 rvalid;
    logic                 master_on;
    logic                 aux_on;
    logic [NUM_PORTS-1:0] gen_on;
  } mai_ctrl_s;

  function automatic logic [3:0] master_of(input logic [7:0] v);
    master_of = v[mai_pkg::MASTER_MSB:mai_pkg::MASTER_LSB];
  endfunction

  function automatic logic [3:0] aux_of(input logic [7:0] v);
    aux_of = v[mai_pkg::AUX_MSB:mai_pkg::AUX_LSB];
  endfunction

  mai_ctrl_s  state_r;
  mai_ctrl_s  state_nxt;
  logic       osc_run;
  logic       osc_running;
  logic [3:0] master_slot;
  logic [3:0] aux_slot;
  logic       addr_hit;

  assign addr_hit = (reg_addr == mai_pkg::INTENS_ADDR);
  assign osc_run  = (master_of(state_r.intens) != mai_pkg::MASTER_OFF);

  mai_pwm_osc #(
    .DIV_W    (16),
    .SLOT_DIV (SLOT_DIV)
  ) u_osc (
    .core_clk    (core_clk),
    .reset       (reset),
    .run         (osc_run),
    .running     (osc_running),
    .master_slot (master_slot),
    .aux_slot    (aux_slot)
  );

  always_comb begin
    logic [3:0] m_lvl;
    logic [3:0] a_lvl;
    logic       m_pwm;
    m_lvl     = master_of(state_r.intens);
    a_lvl     = aux_of(state_r.intens);
    m_pwm     = 1'b0;
    state_nxt = state_r;
    // Both nibbles land in one store so the pair never tears
    if (reg_wr && addr_hit) begin
      state_nxt.intens = reg_wdata;
    end
    state_nxt.rvalid = reg_rd;
    // Unmapped reads answer zero
    state_nxt.rdata  = (reg_rd && addr_hit) ? state_r.intens : 8'h00;
    state_nxt.phase  = blink_phase;
    if (osc_running && m_lvl != mai_pkg::MASTER_OFF) begin
      m_pwm = (master_slot < m_lvl);
    end
    state_nxt.master_on = m_pwm;
    // Aux counts its own 16-slot frame, so its edges need not meet the general ports
    if (a_lvl == mai_pkg::AUX_STATIC) begin
      state_nxt.aux_on = 1'b1;
    end else if (osc_running) begin
      state_nxt.aux_on = (aux_slot <= a_lvl);
    end else begin
      state_nxt.aux_on = 1'b0;
    end
    // One phase flop feeds every port so paralleled ports switch in the same cycle
    state_nxt.gen_on = port_enable & ~(port_phase_sel ^ {NUM_PORTS{state_r.phase}}) & {NUM_PORTS{m_pwm}};
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_r <= '{intens: mai_pkg::INTENS_RESET, phase: 1'b0, rdata: 8'h00, rvalid: 1'b0,
                   master_on: 1'b0, aux_on: 1'b0, gen_on: '0};
    end else begin
      state_r <= state_nxt;
    end
  end

  assign reg_rdata          = state_r.rdata;
  assign reg_rvalid         = state_r.rvalid;
  assign general_port_on    = state_r.gen_on;
  assign aux_output_port_on = state_r.aux_on;
  assign master_pwm_on      = state_r.master_on;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  AST_WRITE_BOTH: assert property (reg_wr && addr_hit |=> state_r.intens == $past(reg_wdata))
    else $error("write did not store both nibbles");
  AST_OTHER_ADDR: assert property (reg_wr && !addr_hit |=> $stable(state_r.intens))
    else $error("write to another address changed intensity");
  AST_READBACK: assert property (reg_rd && addr_hit && !reg_wr |=> reg_rvalid && reg_rdata == $past(state_r.intens))
    else $error("read back did not return stored intensity");
  AST_MASTER_OFF_STATIC: assert property ((master_of(state_r.intens) == mai_pkg::MASTER_OFF) [*3]
                                          |-> !osc_running && general_port_on == '0 && !master_pwm_on)
    else $error("outputs still modulated with master off");
  AST_MASTER_DUTY: assert property (osc_running && master_of(state_r.intens) != mai_pkg::MASTER_OFF
                                    |=> master_pwm_on == ($past(master_slot) < $past(master_of(state_r.intens))))
    else $error("master duty mismatch");
  AST_MASTER_FULL: assert property (osc_running && master_of(state_r.intens) == 4'hf |=> master_pwm_on)
    else $error("full master level not continuously on");
  AST_AUX_DUTY: assert property (osc_running && aux_of(state_r.intens) != mai_pkg::AUX_STATIC
                                 |=> aux_output_port_on == ($past(aux_slot) <= $past(aux_of(state_r.intens))))
    else $error("aux duty mismatch");
  AST_AUX_STATIC: assert property (aux_of(state_r.intens) == mai_pkg::AUX_STATIC |=> aux_output_port_on)
    else $error("aux static level not held");
  AST_SHARED_PHASE: assert property (port_enable == '1 && port_phase_sel == '1
                                     |=> general_port_on == '0 || general_port_on == '1)
    else $error("identically set ports did not switch together");

  // Read answer is valid for each cycle one cycle after the read strobe; the bus idles at zero so a stale byte is never mistaken for data
  AST_RVALID_PULSE: assert property (reg_rd |=> reg_rvalid)
    else $error("read strobe not answered next cycle");
  AST_RDATA_IDLE: assert property (!reg_rd |=> !reg_rvalid && reg_rdata == 8'h00)
    else $error("read answer present without a read strobe");

  // A nonzero master level must keep the frame counters moving
  AST_OSC_FOLLOWS: assert property (osc_run |=> osc_running)
    else $error("oscillator idle with master level set");

  // Ports only sink inside the master on-time and only where enabled
  AST_PORTS_NEED_MASTER: assert property ((|general_port_on) |-> master_pwm_on)
    else $error("general port on outside master on-time");
  AST_PORT_GATING: assert property ((general_port_on & ~$past(port_enable)) == '0)
    else $error("disabled general port switched on");

  // With the frame stopped the aux output is static off unless its level is full
  AST_AUX_IDLE_OFF: assert property (!osc_running && aux_of(state_r.intens) != mai_pkg::AUX_STATIC
                                     |=> !aux_output_port_on)
    else $error("aux output modulated with oscillator stopped");

  COV_MASTER_OFF: cover property (reg_wr && addr_hit && reg_wdata[7:4] == 4'h0);
  COV_MASTER_MID: cover property (osc_running && master_pwm_on ##1 !master_pwm_on);
  COV_AUX_STATIC: cover property (aux_of(state_r.intens) == mai_pkg::AUX_STATIC && osc_running);
  COV_READBACK:   cover property (reg_rd && addr_hit ##1 reg_rvalid);
  COV_AUX_ALONE:  cover property (osc_running && aux_output_port_on && !master_pwm_on);
endmodule
`default_nettype wire

// ---- core/mai_pkg.sv ----
// Constants shared by the master and auxiliary intensity control block
package mai_pkg;
  // Register map
  localparam logic [7:0] INTENS_ADDR  = 8'h0e;
  localparam logic [7:0] INTENS_RESET = 8'h00;
  localparam int         MASTER_MSB   = 7;
  localparam int         MASTER_LSB   = 4;
  localparam int         AUX_MSB      = 3;
  localparam int         AUX_LSB      = 0;
  // Level codes
  localparam logic [3:0] MASTER_OFF   = 4'h0;
  localparam logic [3:0] AUX_STATIC   = 4'hf;
  // Last slot index of each PWM frame: 15 slots for master, 16 for aux
  localparam logic [3:0] MASTER_LAST  = 4'he;
  localparam logic [3:0] AUX_LAST     = 4'hf;
  // Slot timing
  localparam int         CLK_PERIOD_NS = 8;
  localparam int         SLOT_TIME_NS  = 1000;
  localparam int         SLOT_CYCLES   = (SLOT_TIME_NS / CLK_PERIOD_NS < 1) ? 1 : SLOT_TIME_NS / CLK_PERIOD_NS;
  // Oscillator states
  typedef enum logic [1:0] {
    MAI_OSC_IDLE = 2'b01,
    MAI_OSC_RUN  = 2'b10
  } mai_osc_e;
endpackage

// ---- core/mai_pwm_osc.sv ----
// PWM slot oscillator for master and auxiliary frames
`timescale 1ns/1ns
`default_nettype none
module mai_pwm_osc #(
  parameter int DIV_W      = 16,
  parameter int SLOT_DIV   = mai_pkg::SLOT_CYCLES
) (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset,
  // Control
  input  wire logic       run,
  // Slot positions
  output logic            running,
  output logic [3:0]      master_slot,
  output logic [3:0]      aux_slot
);
  typedef struct packed {
    mai_pkg::mai_osc_e st;
    logic [DIV_W-1:0]  div;
    logic [3:0]        m_slot;
    logic [3:0]        a_slot;
  } mai_osc_s;

  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SLOT_DIV - 1);

  mai_osc_s state_r;
  mai_osc_s state_nxt;

  always_comb begin
    state_nxt = state_r;
    case (state_r.st)
      mai_pkg::MAI_OSC_IDLE: begin
        state_nxt.div    = '0;
        state_nxt.m_slot = 4'h0;
        state_nxt.a_slot = 4'h0;
        if (run) begin
          state_nxt.st = mai_pkg::MAI_OSC_RUN;
        end
      end
      mai_pkg::MAI_OSC_RUN: begin
        // Stopping clears the frame so restart always begins at slot 0
        if (!run) begin
          state_nxt.st     = mai_pkg::MAI_OSC_IDLE;
          state_nxt.div    = '0;
          state_nxt.m_slot = 4'h0;
          state_nxt.a_slot = 4'h0;
        end else if (state_r.div == DIV_LAST) begin
          state_nxt.div    = '0;
          state_nxt.m_slot = (state_r.m_slot == mai_pkg::MASTER_LAST) ? 4'h0 : state_r.m_slot + 4'h1;
          state_nxt.a_slot = state_r.a_slot + 4'h1;
        end else begin
          state_nxt.div = state_r.div + DIV_W'(1);
        end
      end
      default: begin
        state_nxt.st = mai_pkg::MAI_OSC_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_r <= '{st: mai_pkg::MAI_OSC_IDLE, div: '0, m_slot: 4'h0, a_slot: 4'h0};
    end else begin
      state_r <= state_nxt;
    end
  end

  assign running     = (state_r.st == mai_pkg::MAI_OSC_RUN);
  assign master_slot = state_r.m_slot;
  assign aux_slot    = state_r.a_slot;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  AST_MASTER_FRAME: assert property (master_slot <= mai_pkg::MASTER_LAST)
    else $error("master slot left its 15-slot frame");
  AST_STOP_CLEARS: assert property (!run |=> !running && master_slot == 4'h0 && aux_slot == 4'h0)
    else $error("oscillator kept running with master off");
endmodule
`default_nettype wire

// ---- bench/mai_host_model.sv ----
// Host model that drives the intensity register bus
`timescale 1ns/1ns
`default_nettype none
module mai_host_model (
  // Clock
  input  wire logic       core_clk,
  // Register bus
  output logic            reg_wr,
  output logic            reg_rd,
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // Released address and data lines show the inverse and both strobes drop low, so a stale value is never taken as live
  task automatic release_bus();
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~reg_addr;
    reg_wdata = ~reg_wdata;
  endtask
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(negedge core_clk);
    reg_wr = 1'b1;
    reg_addr = addr;
    reg_wdata = data;
    @(negedge core_clk);
    release_bus();
  endtask
  task automatic rd(input logic [7:0] addr, output logic [7:0] data, output logic vld);
    @(negedge core_clk);
    reg_rd = 1'b1;
    reg_addr = addr;
    @(negedge core_clk);
    release_bus();
    vld = reg_rvalid;
    data = reg_rdata;
  endtask
endmodule
`default_nettype wire

// ---- bench/tb_top.sv ----
// Self-checking testbench for the intensity control block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  localparam int SD = 2;
  logic       core_clk;
  logic       reset;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic       reg_rvalid;
  logic [7:0] port_enable;
  logic [7:0] port_phase_sel;
  logic       blink_phase;
  logic [7:0] general_port_on;
  logic       aux_output_port_on;
  logic       master_pwm_on;
  int         n_mismatch = 0;
  int         total_checks = 0;
  int         cyc = 0;
  mai_intensity_ctrl #(.NUM_PORTS(8), .SLOT_DIV(SD)) mai_intensity_ctrl_i (
    .core_clk(core_clk), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .port_enable(port_enable),
    .port_phase_sel(port_phase_sel), .blink_phase(blink_phase), .general_port_on(general_port_on),
    .aux_output_port_on(aux_output_port_on), .master_pwm_on(master_pwm_on));
  mai_host_model mai_host_model_i (
    .core_clk(core_clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task automatic results();
    if (n_mismatch == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Longest run is a few thousand cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 8000) begin
      n_mismatch++;
      results();
    end
  end
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic rdchk(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    logic       v;
    mai_host_model_i.rd(addr, d, v);
    chk("rvalid", {15'h0, v}, 16'h0001);
    chk("rdata", {8'h00, d}, {8'h00, exp});
    @(negedge core_clk);
    chk("rvalid_end", {15'h0, reg_rvalid}, 16'h0000);
    chk("rdata_end", {8'h00, reg_rdata}, 16'h0000);
  endtask
  // Mid-run reset with the frame running must bring everything back to master off
  task automatic t_reset();
    @(negedge core_clk);
    reset = 1'b1;
    repeat (2) @(negedge core_clk);
    reset = 1'b0;
    chk("reset_outputs", {5'h00, reg_rvalid, general_port_on, aux_output_port_on, master_pwm_on}, 16'h0000);
    rdchk(8'h0e, mai_pkg::INTENS_RESET);
  endtask
  task automatic t_regs();
    rdchk(8'h0e, mai_pkg::INTENS_RESET);
    chk("outputs", {6'h00, general_port_on, aux_output_port_on, master_pwm_on}, 16'h0000);
    mai_host_model_i.wr(8'h0e, 8'ha5);
    rdchk(8'h0e, 8'ha5);
    mai_host_model_i.wr(8'h0f, 8'h3c);
    rdchk(8'h0e, 8'ha5);
    rdchk(8'h0f, 8'h00);
  endtask
  // One window of 240 slots spans whole master and aux frames alike
  task automatic t_duty(input logic [7:0] val);
    logic [15:0] nm;
    logic [15:0] na;
    logic [15:0] ng;
    logic [7:0]  gm;
    nm = 16'h0000;
    na = 16'h0000;
    ng = 16'h0000;
    gm = port_enable & ~(port_phase_sel ^ {8{blink_phase}});
    mai_host_model_i.wr(8'h0e, val);
    rdchk(8'h0e, val);
    repeat (8) @(negedge core_clk);
    repeat (240 * SD) begin
      @(negedge core_clk);
      if (master_pwm_on === 1'b1) nm++;
      if (aux_output_port_on === 1'b1) na++;
      if (general_port_on !== (gm & {8{master_pwm_on}})) ng++;
    end
    chk("master_on", nm, 16'(val[7:4]) * 16'(16 * SD));
    if (val[3:0] == 4'hf) chk("aux_on", na, 16'(240 * SD));
    else if (val[7:4] == 4'h0) chk("aux_on", na, 16'h0000);
    else chk("aux_on", na, (16'(val[3:0]) + 16'h0001) * 16'(15 * SD));
    chk("port_mismatch", ng, 16'h0000);
  endtask
  initial begin
    reset = 1'b1;
    port_enable = 8'hff;
    port_phase_sel = 8'hff;
    blink_phase = 1'b1;
    repeat (3) @(negedge core_clk);
    reset = 1'b0;
    t_regs();
    t_duty(8'h10);
    t_duty(8'h7e);
    t_duty(8'hf0);
    @(negedge core_clk);
    port_enable = 8'ha5;
    port_phase_sel = 8'h0f;
    blink_phase = 1'b0;
    t_duty(8'h37);
    t_reset();
    t_duty(8'h05);
    t_duty(8'h0f);
    results();
  end
endmodule
`default_nettype wire
